// ==== int_prio_defines.vh ====
// Register offsets, field positions, reset values, source order indices and power fail level of the interrupt controller.
`ifndef INT_PRIO_DEFINES_VH
`define INT_PRIO_DEFINES_VH
// Register byte offsets on the APB bus.
`define OFS_IE 12'h000
`define OFS_XEN 12'h004
`define OFS_PLO 12'h008
`define OFS_PHI 12'h00C
`define OFS_XPLO 12'h010
`define OFS_XPHI 12'h014
`define OFS_TCTL 12'h018
`define OFS_XFLG 12'h01C
`define OFS_SER 12'h020
`define OFS_T2 12'h024
`define OFS_WD 12'h028
`define OFS_STAT 12'h02C
`define OFS_ACK 12'h030
// Reset values.
`define RST_BYTE 8'h00
`define RST_IDLE_LVL 3'h0
// Field positions in the timer control register.
`define TC_IT0 0
`define TC_X0F 1
`define TC_IT1 2
`define TC_X1F 3
`define TC_T0F 5
`define TC_T1F 7
// Field positions in the watchdog control register.
`define WD_WDF 3
`define WD_PFF 4
`define WD_PFE 5
// Field positions in the serial register: port 0 in bits 1:0, port 1 in bits 3:2.
`define SR_RI0 0
`define SR_TI0 1
`define SR_RI1 2
`define SR_TI1 3
// Field positions in the timer 2 register.
`define T2_EVF 6
`define T2_OVF 7
// Source order indices.
`define SRC_PF 0
`define SRC_X0 1
`define SRC_T0 2
`define SRC_X1 3
`define SRC_T1 4
`define NSRC 13
// Power fail level.
`define LVL_PF 3'h4
`endif

// ==== interrupt_priority_vectoring.v ====
// Interrupt flag latching, priority arbitration and vector generation with an APB register port.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "int_prio_defines.vh"

module interrupt_priority_vectoring (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire ext_int0_pin_n,
  input wire ext_int1_pin_n,
  input wire [3:0] ext_int_hi_event,
  input wire timer0_overflow_event,
  input wire timer1_overflow_event,
  input wire timer2_overflow_event,
  input wire timer2_ext_event,
  input wire serial0_rx_event,
  input wire serial0_tx_event,
  input wire serial1_rx_event,
  input wire serial1_tx_event,
  input wire watchdog_event,
  input wire power_fail_event,
  input wire global_int_enable,
  output reg int_request,
  output reg [7:0] int_vector,
  input wire vector_taken,
  input wire service_return
);

  ////////////////////////////////////////////////////////////////////////
  // Vector address of each source by natural order.
  function [7:0] vec_of;
    input [3:0] idx;
    begin
      case (idx)
        4'd0: vec_of = 8'h33;
        4'd1: vec_of = 8'h03;
        4'd2: vec_of = 8'h0B;
        4'd3: vec_of = 8'h13;
        4'd4: vec_of = 8'h1B;
        4'd5: vec_of = 8'h23;
        4'd6: vec_of = 8'h2B;
        4'd7: vec_of = 8'h3B;
        4'd8: vec_of = 8'h43;
        4'd9: vec_of = 8'h4B;
        4'd10: vec_of = 8'h53;
        4'd11: vec_of = 8'h5B;
        4'd12: vec_of = 8'h63;
        default: vec_of = 8'h00;
      endcase
    end
  endfunction

  // Write strobe for one register offset.
  function wr_hit;
    input [11:0] ofs;
    begin
      wr_hit = psel & penable & pwrite & (paddr == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register state.
  reg [7:0] ie_reg, ext_int_enable_reg, prio_low_bits_reg, prio_high_bits_reg;
  reg [7:0] ext_prio_low_bits_reg, ext_prio_high_bits_reg;
  reg [7:0] timer_ctrl_reg, ext_flag_reg, ser_reg, t2_reg, wd_reg;
  // Pin synchronisers: three stages, the last two must agree.
  reg [2:0] x0_sync_reg, x1_sync_reg;
  reg x0_stable_reg, x1_stable_reg;
  // Levels of routines in progress, one bit per level 0..4.
  reg [4:0] active_reg;
  reg [3:0] vec_idx_reg;

  // Registers answer in the access cycle; no wait states and no errors.
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Synchronise the active low external pins; a change counts only once stage 2 and 3 agree.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x0_sync_reg <= 3'b111;
      x1_sync_reg <= 3'b111;
      x0_stable_reg <= 1'b1;
      x1_stable_reg <= 1'b1;
    end else begin
      x0_sync_reg <= {x0_sync_reg[1:0], ext_int0_pin_n};
      x1_sync_reg <= {x1_sync_reg[1:0], ext_int1_pin_n};
      if (x0_sync_reg[1] == x0_sync_reg[2])
        x0_stable_reg <= x0_sync_reg[2];
      if (x1_sync_reg[1] == x1_sync_reg[2])
        x1_stable_reg <= x1_sync_reg[2];
    end
  end

  // Pin conditions: falling edge in edge mode, low level in level mode.
  wire x0_fall = x0_stable_reg & ~x0_sync_reg[2] & (x0_sync_reg[1] == x0_sync_reg[2]);
  wire x1_fall = x1_stable_reg & ~x1_sync_reg[2] & (x1_sync_reg[1] == x1_sync_reg[2]);
  wire x0_low = ~x0_stable_reg;
  wire x1_low = ~x1_stable_reg;

  ////////////////////////////////////////////////////////////////////////
  // Arbitration.
  reg [12:0] pend;
  reg [2:0] lvl [0:12];
  reg [2:0] best_lvl;
  reg [3:0] best_idx;
  reg found;
  reg [2:0] cur_lvl;
  integer i;
  always @* begin
    pend[0] = wd_reg[`WD_PFF] & wd_reg[`WD_PFE];
    pend[1] = timer_ctrl_reg[`TC_X0F] & ie_reg[0];
    pend[2] = timer_ctrl_reg[`TC_T0F] & ie_reg[1];
    pend[3] = timer_ctrl_reg[`TC_X1F] & ie_reg[2];
    pend[4] = timer_ctrl_reg[`TC_T1F] & ie_reg[3];
    pend[5] = (ser_reg[`SR_RI0] | ser_reg[`SR_TI0]) & ie_reg[4];
    pend[6] = (t2_reg[`T2_OVF] | t2_reg[`T2_EVF]) & ie_reg[5];
    pend[7] = (ser_reg[`SR_RI1] | ser_reg[`SR_TI1]) & ie_reg[6];
    pend[8] = ext_flag_reg[4] & ext_int_enable_reg[0];
    pend[9] = ext_flag_reg[5] & ext_int_enable_reg[1];
    pend[10] = ext_flag_reg[6] & ext_int_enable_reg[2];
    pend[11] = ext_flag_reg[7] & ext_int_enable_reg[3];
    pend[12] = wd_reg[`WD_WDF] & ext_int_enable_reg[4];
    lvl[0] = `LVL_PF;
    // Level bits: high from second set, low from first.
    for (i = 0; i < 7; i = i + 1)
      lvl[i + 1] = {1'b0, prio_high_bits_reg[i], prio_low_bits_reg[i]};
    for (i = 0; i < 5; i = i + 1)
      lvl[i + 8] = {1'b0, ext_prio_high_bits_reg[i], ext_prio_low_bits_reg[i]};
    // Strictly greater replaces, so the lowest order wins a tie.
    best_lvl = 3'd0;
    best_idx = 4'd0;
    found = 1'b0;
    for (i = 0; i < `NSRC; i = i + 1) begin
      if (pend[i] && (!found || lvl[i] > best_lvl)) begin
        found = 1'b1;
        best_lvl = lvl[i];
        best_idx = i[3:0];
      end
    end
    // Highest level in progress; no routine acts as below level 0.
    cur_lvl = 3'd0;
    for (i = 0; i < 5; i = i + 1)
      if (active_reg[i])
        cur_lvl = i[2:0];
  end

  // A new request must beat every routine in progress.
  wire may_take = found & global_int_enable &
                  (active_reg == 5'b0 || best_lvl > cur_lvl);

  // Present the request and its vector; the request follows may_take each cycle and drops when the core vectors.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_request <= 1'b0;
      int_vector <= 8'h00;
      vec_idx_reg <= 4'd0;
    end else if (vector_taken) begin
      int_request <= 1'b0;
    end else begin
      int_request <= may_take;
      // The vector stands with the request, so the core never takes a moving vector.
      if (!int_request || !may_take) begin
        int_vector <= vec_of(best_idx);
        vec_idx_reg <= best_idx;
      end
    end
  end

  // Track levels in progress; return ends the highest one.
  reg [4:0] act_next;
  always @* begin
    act_next = active_reg;
    if (service_return) begin
      if (active_reg[4]) act_next[4] = 1'b0;
      else if (active_reg[3]) act_next[3] = 1'b0;
      else if (active_reg[2]) act_next[2] = 1'b0;
      else if (active_reg[1]) act_next[1] = 1'b0;
      else act_next[0] = 1'b0;
    end
    if (vector_taken && int_request)
      act_next[lvl[vec_idx_reg]] = 1'b1;
  end

  wire took = vector_taken & int_request;

  ////////////////////////////////////////////////////////////////////////
  // Registers and flags. Hardware set wins over a software clear in the same cycle.
  reg [7:0] timer_ctrl_next, ext_flag_next, ser_next, t2_next, wd_next;
  always @* begin
    timer_ctrl_next = wr_hit(`OFS_TCTL) ? pwdata[7:0] : timer_ctrl_reg;
    ext_flag_next = wr_hit(`OFS_XFLG) ? pwdata[7:0] : ext_flag_reg;
    ser_next = wr_hit(`OFS_SER) ? pwdata[7:0] : ser_reg;
    t2_next = wr_hit(`OFS_T2) ? pwdata[7:0] : t2_reg;
    wd_next = wr_hit(`OFS_WD) ? pwdata[7:0] : wd_reg;
    // Hardware clear on vectoring, before the sets so that a new event survives.
    if (took && vec_idx_reg == `SRC_X0 && timer_ctrl_reg[`TC_IT0])
      timer_ctrl_next[`TC_X0F] = 1'b0;
    if (took && vec_idx_reg == `SRC_X1 && timer_ctrl_reg[`TC_IT1])
      timer_ctrl_next[`TC_X1F] = 1'b0;
    if (took && vec_idx_reg == `SRC_T0)
      timer_ctrl_next[`TC_T0F] = 1'b0;
    if (took && vec_idx_reg == `SRC_T1)
      timer_ctrl_next[`TC_T1F] = 1'b0;
    // Event sets, independent of enables.
    if (timer_ctrl_next[`TC_IT0]) begin
      if (x0_fall) timer_ctrl_next[`TC_X0F] = 1'b1;
    end else
      timer_ctrl_next[`TC_X0F] = x0_low;
    if (timer_ctrl_next[`TC_IT1]) begin
      if (x1_fall) timer_ctrl_next[`TC_X1F] = 1'b1;
    end else
      timer_ctrl_next[`TC_X1F] = x1_low;
    if (timer0_overflow_event) timer_ctrl_next[`TC_T0F] = 1'b1;
    if (timer1_overflow_event) timer_ctrl_next[`TC_T1F] = 1'b1;
    ext_flag_next[7:4] = ext_flag_next[7:4] | ext_int_hi_event;
    if (serial0_rx_event) ser_next[`SR_RI0] = 1'b1;
    if (serial0_tx_event) ser_next[`SR_TI0] = 1'b1;
    if (serial1_rx_event) ser_next[`SR_RI1] = 1'b1;
    if (serial1_tx_event) ser_next[`SR_TI1] = 1'b1;
    if (timer2_overflow_event) t2_next[`T2_OVF] = 1'b1;
    if (timer2_ext_event) t2_next[`T2_EVF] = 1'b1;
    if (watchdog_event) wd_next[`WD_WDF] = 1'b1;
    if (power_fail_event) wd_next[`WD_PFF] = 1'b1;
    ser_next[7:4] = 4'h0;
  end

  // Register update; enables and priorities are plain software bits.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_reg <= `RST_BYTE;
      ext_int_enable_reg <= `RST_BYTE;
      prio_low_bits_reg <= `RST_BYTE;
      prio_high_bits_reg <= `RST_BYTE;
      ext_prio_low_bits_reg <= `RST_BYTE;
      ext_prio_high_bits_reg <= `RST_BYTE;
      timer_ctrl_reg <= `RST_BYTE;
      ext_flag_reg <= `RST_BYTE;
      ser_reg <= `RST_BYTE;
      t2_reg <= `RST_BYTE;
      wd_reg <= `RST_BYTE;
      active_reg <= 5'b0;
    end else begin
      if (wr_hit(`OFS_IE)) ie_reg <= pwdata[7:0];
      if (wr_hit(`OFS_XEN)) ext_int_enable_reg <= {3'b000, pwdata[4:0]};
      if (wr_hit(`OFS_PLO)) prio_low_bits_reg <= {1'b0, pwdata[6:0]};
      if (wr_hit(`OFS_PHI)) prio_high_bits_reg <= {1'b0, pwdata[6:0]};
      if (wr_hit(`OFS_XPLO)) ext_prio_low_bits_reg <= {3'b000, pwdata[4:0]};
      if (wr_hit(`OFS_XPHI)) ext_prio_high_bits_reg <= {3'b000, pwdata[4:0]};
      timer_ctrl_reg <= timer_ctrl_next;
      ext_flag_reg <= ext_flag_next;
      ser_reg <= ser_next;
      t2_reg <= t2_next;
      wd_reg <= wd_next;
      active_reg <= act_next;
    end
  end

  // Read data, registered on the setup cycle so that it is stable in the access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFS_IE: prdata <= {24'h00_0000, ie_reg};
        `OFS_XEN: prdata <= {24'h00_0000, ext_int_enable_reg};
        `OFS_PLO: prdata <= {24'h00_0000, prio_low_bits_reg};
        `OFS_PHI: prdata <= {24'h00_0000, prio_high_bits_reg};
        `OFS_XPLO: prdata <= {24'h00_0000, ext_prio_low_bits_reg};
        `OFS_XPHI: prdata <= {24'h00_0000, ext_prio_high_bits_reg};
        `OFS_TCTL: prdata <= {24'h00_0000, timer_ctrl_reg};
        `OFS_XFLG: prdata <= {24'h00_0000, ext_flag_reg};
        `OFS_SER: prdata <= {24'h00_0000, ser_reg};
        `OFS_T2: prdata <= {24'h00_0000, t2_reg};
        `OFS_WD: prdata <= {24'h00_0000, wd_reg};
        `OFS_STAT: prdata <= {19'h0_0000, active_reg, vec_idx_reg, int_request, best_lvl};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // interrupt_priority_vectoring
`default_nettype wire

// ==== int_prio_chk_assertions.sv ====
// Concurrent checks on the ports of the interrupt priority block.
`timescale 1ns/1ps
`default_nettype none
module int_prio_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_int_enable,
  input wire logic int_request,
  input wire logic [7:0] int_vector,
  input wire logic vector_taken
);
  ////////////////////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A request that the core takes, and a read setup cycle.
  sequence s_take; int_request && vector_taken; endsequence
  sequence s_rd_setup; psel && !penable && !pwrite; endsequence
  // Request and vector rules.
  take_drop_a: assert property (s_take |=> !int_request)
    else $error("Request still high after it was taken");
  vec_legal_a: assert property (int_request |-> int_vector inside {8'h03, 8'h0B, 8'h13,
    8'h1B, 8'h23, 8'h2B, 8'h33, 8'h3B, 8'h43, 8'h4B, 8'h53, 8'h5B, 8'h63})
    else $error("Vector outside the vector table");
  gie_gate_a: assert property ($rose(int_request) |-> $past(global_int_enable))
    else $error("Request raised while requests were gated off");
  // Bus rules; read data only moves after a read setup.
  rd_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("Read data moved without a read setup");
  unmap_zero_a: assert property (psel && penable && !pwrite && paddr > 12'h030 |-> prdata == 0)
    else $error("Unmapped read gave nonzero data");
  hi_zero_a: assert property (psel && penable |-> prdata[31:13] == 19'h0_0000)
    else $error("Unused read bits not zero");
  ready_a: assert property (pready) else $error("Bus not ready");
  no_err_a: assert property (!pslverr) else $error("Bus error reported");
endmodule // int_prio_chk
`default_nettype wire

// ==== core_model.sv ====
// Behavioural processor core that takes vectors and returns from service.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic int_request,
  input wire logic [7:0] int_vector,
  input wire logic [3:0] lag,
  output logic vector_taken,
  output logic service_return,
  output logic [7:0] got
);
  logic busy;
  logic [3:0] cnt;
  // Take a request after lag cycles, serve it for sixteen, then return.
  // Nesting is not modelled, so a higher level waits for the return too.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_taken <= 1'b0;
      service_return <= 1'b0;
      got <= 8'h00;
      busy <= 1'b0;
      cnt <= 4'h0;
    end else begin
      vector_taken <= 1'b0;
      service_return <= 1'b0;
      cnt <= cnt + 4'h1;
      if (busy) begin
        busy <= (cnt != 4'hF);
        service_return <= (cnt == 4'hF);
      end else if (!int_request || vector_taken) begin
        cnt <= 4'h0;
      end else if (cnt == lag) begin
        vector_taken <= 1'b1;
        got <= int_vector;
        busy <= 1'b1;
        cnt <= 4'h0;
      end
    end
  end
endmodule // core_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the interrupt priority and vectoring block.
`timescale 1ns/1ps
`default_nettype none
`include "int_prio_defines.vh"
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, int_request, vector_taken, service_return;
  logic [7:0] int_vector, got;
  logic ext_int0_pin_n = 1, ext_int1_pin_n = 1, global_int_enable = 1;
  logic [15:0] ev = 0;
  logic [3:0] lag = 0;
  int failures = 0, compares = 0, i, k, r;
  typedef struct {int b; logic [11:0] a; logic [7:0] e; logic [7:0] v;} row_t;
  // Rows: event bit, enable register, enable value, expected vector.
  row_t rows [14] = '{'{0, `OFS_WD, 8'h20, 8'h33}, '{2, `OFS_IE, 8'h02, 8'h0B},
    '{4, `OFS_IE, 8'h08, 8'h1B}, '{5, `OFS_IE, 8'h10, 8'h23}, '{13, `OFS_IE, 8'h10, 8'h23},
    '{6, `OFS_IE, 8'h20, 8'h2B}, '{14, `OFS_IE, 8'h20, 8'h2B}, '{7, `OFS_IE, 8'h40, 8'h3B},
    '{15, `OFS_IE, 8'h40, 8'h3B}, '{8, `OFS_XEN, 8'h01, 8'h43}, '{9, `OFS_XEN, 8'h02, 8'h4B},
    '{10, `OFS_XEN, 8'h04, 8'h53}, '{11, `OFS_XEN, 8'h08, 8'h5B}, '{12, `OFS_XEN, 8'h10, 8'h63}};
  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Clock, design and core model.
  always #2.5 pclk = ~pclk;
  interrupt_priority_vectoring u_interrupt_priority_vectoring (.*, .power_fail_event(ev[0]),
    .timer0_overflow_event(ev[2]), .timer1_overflow_event(ev[4]), .serial0_rx_event(ev[5]),
    .timer2_overflow_event(ev[6]), .serial1_tx_event(ev[7]), .ext_int_hi_event(ev[11:8]),
    .watchdog_event(ev[12]), .serial0_tx_event(ev[13]), .timer2_ext_event(ev[14]),
    .serial1_rx_event(ev[15]));
  core_model u_core_model (.*);
  // Shared bus, pulse and comparison tasks.
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task pulse(input logic [15:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 0;
  endtask
  // Waits for the core to take a vector, then for its return.
  task vec(input logic [7:0] v);
    for (i = 0; i < 60 && vector_taken !== 1'b1; i++) @(negedge pclk);
    chk("vector", {23'h00_0000, 1'b1, v}, {23'h00_0000, vector_taken, int_vector});
    chk("core vector", {24'h00_0000, v}, {24'h00_0000, got});
    for (i = 0; i < 60 && service_return !== 1'b1; i++) @(negedge pclk);
    @(posedge pclk);
  endtask
  // Software clears every flag and enable, so nothing is left pending.
  task quiet;
    for (k = 0; k < 11; k++) apb(1, 12'(k * 4), 0);
    repeat (20) @(posedge pclk);
  endtask
  task tally_and_finish;
    $display("Comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (k = 0; k < 12; k++) begin
      apb(0, 12'(k * 4), 0);
      chk("reset value", 0, rd);
    end
    apb(1, 12'h040, 32'h0000_00FF);
    apb(0, 12'h040, 0);
    chk("unmapped", 0, rd);
    for (r = 0; r < 14; r++) begin
      lag <= 4'(r % 4);
      apb(1, rows[r].a, {24'h00_0000, rows[r].e});
      pulse(16'h0001 << rows[r].b);
      vec(rows[r].v);
      quiet;
    end
    // Equal levels go by order; a raised level beats order; power fail beats all.
    apb(1, `OFS_IE, 32'h0000_007F);
    pulse(16'h0030);
    vec(8'h1B);
    vec(8'h23);
    quiet;
    apb(1, `OFS_PHI, 32'h0000_0010);
    apb(1, `OFS_IE, 32'h0000_007F);
    pulse(16'h0030);
    vec(8'h23);
    quiet;
    apb(1, `OFS_PLO, 32'h0000_0010);
    apb(1, `OFS_PHI, 32'h0000_0010);
    apb(1, `OFS_WD, 32'h0000_0020);
    apb(1, `OFS_IE, 32'h0000_007F);
    pulse(16'h0021);
    vec(8'h33);
    quiet;
    // A disabled source still flags; timer 0 flag is cleared by vectoring.
    pulse(16'h0040);
    apb(0, `OFS_T2, 0);
    chk("flag while disabled", 32'h0000_0080, rd);
    quiet;
    global_int_enable <= 0;
    apb(1, `OFS_IE, 32'h0000_0002);
    pulse(16'h0004);
    repeat (10) @(posedge pclk);
    chk("gated request", 0, {31'h0000_0000, int_request});
    global_int_enable <= 1;
    vec(8'h0B);
    apb(0, `OFS_TCTL, 0);
    chk("timer0 flag", 0, rd);
    quiet;
    // External 0 on an edge, external 1 on a level.
    apb(1, `OFS_TCTL, 32'h0000_0001);
    apb(1, `OFS_IE, 32'h0000_0001);
    ext_int0_pin_n <= 0;
    vec(8'h03);
    apb(0, `OFS_TCTL, 0);
    chk("edge flag", 32'h0000_0001, rd);
    ext_int0_pin_n <= 1;
    quiet;
    apb(1, `OFS_IE, 32'h0000_0004);
    ext_int1_pin_n <= 0;
    vec(8'h13);
    apb(0, `OFS_TCTL, 0);
    chk("level flag low", 32'h0000_0008, rd);
    ext_int1_pin_n <= 1;
    repeat (6) @(posedge pclk);
    apb(0, `OFS_TCTL, 0);
    chk("level flag high", 0, rd);
    // A reset in mid-run clears the registers.
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `OFS_IE, 0);
    chk("second reset", 0, rd);
    tally_and_finish;
  end
  // Watchdog against a hang.
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    tally_and_finish;
  end
endmodule // tb_top
bind interrupt_priority_vectoring int_prio_chk u_int_prio_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .global_int_enable, .int_request, .int_vector,
  .vector_taken);
`default_nettype wire
